/* design/msp_dev.sv */
// device end: bus cycle follower, register map and status register
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
module msp_dev
    import msp_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic rst, // synchronous reset, active high
    msp_bus_if.dev bus, // multiplexed bus to the host
    input wire logic spi_done, // current byte has finished shifting
    input wire logic spi_bus_active, // an outgoing select is asserted
    input wire logic ss_in_n, // external select, active low
    input wire logic tx_taken, // shifter took the transmit byte
    input wire logic rx_valid, // shifter delivers a received byte
    input wire logic [7:0] rx_byte, // received byte
    output logic [7:0] ctrl_out, // control register contents
    output logic [7:0] target_sel, // target select register contents
    output logic [7:0] tx_byte, // transmit holding register
    output logic tx_empty, // transmit register is empty
    output logic rx_full, // receive register holds data
    output logic int_n, // interrupt request, active low
    output logic spi_abort // bus conflict: reset and float serial side
);
    typedef struct packed {
        msp_dev_st_t st;
        logic [7:0] alo;
        logic [7:0] ad_o;
        logic ad_oe_n;
        logic [7:0] ctrl;
        logic [7:0] tsel;
        logic [7:0] txd;
        logic [7:0] rxd;
        logic conflict;
        logic pend;
        logic tx_empty;
        logic rx_full;
        logic cond;
    } msp_dev_state_t;

    msp_dev_state_t s_q;
    msp_dev_state_t s_d;

    logic hit;
    logic [15:0] full_addr;
    logic [7:0] status_val;
    logic cond_now;
    logic do_wr;
    logic do_rd;
    logic clr_pend;
    logic [7:0] rd_val;

    // only the upper twelve bits are compared, so every register must
    // share one sixteen-byte page above the base
    assign full_addr = {bus.addr_hi, s_q.alo};
    assign hit = full_addr[15:4] == MSP_STATUS_ADDR[15:4];

    always_comb
    begin
        status_val = 8'h00;
        status_val[MSP_ST_DONE] = spi_done;
        status_val[MSP_ST_CONFLICT] = s_q.conflict;
        status_val[MSP_ST_BUSY] = spi_bus_active;
        status_val[MSP_ST_INT_N] = ~s_q.pend;
        status_val[MSP_ST_TX_EMPTY] = s_q.tx_empty;
        status_val[MSP_ST_RX_FULL] = s_q.rx_full;
    end

    always_comb
    begin
        case (full_addr)
            MSP_STATUS_ADDR: rd_val = status_val;
            MSP_CONTROL_ADDR: rd_val = s_q.ctrl;
            MSP_TARGET_ADDR: rd_val = s_q.tsel;
            MSP_RX_ADDR: rd_val = s_q.rxd;
            default: rd_val = 8'h00;
        endcase
    end

    // accesses happen once, on entry to the transfer state
    assign do_wr = s_q.st == MSP_D_DECODE && !bus.ale_n && hit
                   && !bus.wr_n;
    assign do_rd = s_q.st == MSP_D_DECODE && !bus.ale_n && hit
                   && bus.wr_n && !bus.rd_n;

    always_comb
    begin
        s_d = s_q;
        clr_pend = 1'b0;
        case (s_q.st)
            MSP_D_IDLE:
            begin
                s_d.ad_oe_n = 1'b1;
                if (!bus.ale_n)
                begin
                    s_d.alo = bus.ad;
                    s_d.st = MSP_D_DECODE;
                end
            end
            MSP_D_DECODE:
            begin
                if (bus.ale_n)
                    s_d.st = MSP_D_IDLE;
                else if (do_wr || do_rd)
                    s_d.st = MSP_D_XFER;
            end
            MSP_D_XFER:
            begin
                if (bus.ale_n)
                begin
                    s_d.ad_oe_n = 1'b1;
                    s_d.st = MSP_D_IDLE;
                end
                else if (bus.rd_n && bus.wr_n)
                begin
                    s_d.ad_oe_n = 1'b1;
                    s_d.st = MSP_D_END;
                end
            end
            MSP_D_END:
            begin
                s_d.ad_oe_n = 1'b1;
                if (bus.ale_n)
                    s_d.st = MSP_D_IDLE;
            end
            default:
            begin
                s_d.ad_oe_n = 1'b1;
                s_d.st = MSP_D_IDLE;
            end
        endcase

        if (do_rd)
        begin
            s_d.ad_o = rd_val;
            s_d.ad_oe_n = 1'b0;
            if (full_addr == MSP_RX_ADDR)
            begin
                s_d.rx_full = 1'b0;
                clr_pend = 1'b1;
            end
        end

        if (do_wr)
        begin
            case (full_addr)
                MSP_STATUS_ADDR:
                begin
                    // only the error flag may be written, and only to zero
                    if (!bus.ad[MSP_ST_CONFLICT] && s_q.conflict)
                    begin
                        s_d.conflict = 1'b0;
                        clr_pend = 1'b1;
                    end
                end
                MSP_CONTROL_ADDR: s_d.ctrl = bus.ad;
                MSP_TARGET_ADDR: s_d.tsel = bus.ad;
                MSP_TX_ADDR:
                begin
                    s_d.txd = bus.ad;
                    s_d.tx_empty = 1'b0;
                    clr_pend = 1'b1;
                end
                default: s_d.ctrl = s_q.ctrl;
            endcase
        end

        // a byte taken by the shifter in the same cycle as a write leaves
        // the new byte held, so the write keeps the register full
        if (tx_taken && !(do_wr && full_addr == MSP_TX_ADDR))
            s_d.tx_empty = 1'b1;
        if (rx_valid)
        begin
            s_d.rxd = rx_byte;
            s_d.rx_full = 1'b1;
        end
        if (!ss_in_n)
            s_d.conflict = 1'b1;

        if (clr_pend)
            s_d.pend = 1'b0;
        // causes are taken from the new flag values so an edge is seen once
        cond_now = (s_d.tx_empty && s_d.ctrl[MSP_CT_START])
                   || (s_d.rx_full && !s_d.ctrl[MSP_CT_START])
                   || s_d.conflict;
        s_d.cond = cond_now;
        if (cond_now && !s_q.cond)
            s_d.pend = 1'b1;

        if (rst)
        begin
            s_d.st = MSP_D_IDLE;
            s_d.alo = 8'h00;
            s_d.ad_o = 8'h00;
            s_d.ad_oe_n = 1'b1;
            s_d.ctrl = MSP_REG_RESET;
            s_d.tsel = MSP_REG_RESET;
            s_d.txd = MSP_REG_RESET;
            s_d.rxd = MSP_REG_RESET;
            s_d.conflict = 1'b0;
            s_d.pend = 1'b0;
            s_d.tx_empty = 1'b1;
            s_d.rx_full = 1'b0;
            s_d.cond = 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        s_q <= s_d;
    end

    assign bus.dev_ad_o = s_q.ad_o;
    assign bus.dev_ad_oe_n = s_q.ad_oe_n;
    assign ctrl_out = s_q.ctrl;
    assign target_sel = s_q.tsel;
    assign tx_byte = s_q.txd;
    assign tx_empty = s_q.tx_empty;
    assign rx_full = s_q.rx_full;
    assign int_n = ~(s_q.pend && s_q.ctrl[MSP_CT_IRQ_EN]);
    assign spi_abort = s_q.conflict;
endmodule

/* design/msp_pkg.sv */
// shared constants and types for the multiplexed-bus status port
package msp_pkg;
    // device address map: base plus offset, low nibble selects
    localparam logic [15:0] MSP_BASE = 16'h0000;
    localparam logic [15:0] MSP_STATUS_OFS = 16'h0080;
    localparam logic [15:0] MSP_CONTROL_OFS = 16'h0084;
    localparam logic [15:0] MSP_TARGET_OFS = 16'h0088;
    localparam logic [15:0] MSP_TX_OFS = 16'h008a;
    localparam logic [15:0] MSP_RX_OFS = 16'h008e;
    localparam logic [15:0] MSP_STATUS_ADDR = MSP_BASE + MSP_STATUS_OFS;
    localparam logic [15:0] MSP_CONTROL_ADDR = MSP_BASE + MSP_CONTROL_OFS;
    localparam logic [15:0] MSP_TARGET_ADDR = MSP_BASE + MSP_TARGET_OFS;
    localparam logic [15:0] MSP_TX_ADDR = MSP_BASE + MSP_TX_OFS;
    localparam logic [15:0] MSP_RX_ADDR = MSP_BASE + MSP_RX_OFS;

    // status field positions
    localparam int MSP_ST_DONE = 7;
    localparam int MSP_ST_CONFLICT = 6;
    localparam int MSP_ST_BUSY = 5;
    localparam int MSP_ST_INT_N = 4;
    localparam int MSP_ST_TX_EMPTY = 3;
    localparam int MSP_ST_RX_FULL = 2;
    // control field positions
    localparam int MSP_CT_IRQ_EN = 6;
    localparam int MSP_CT_START = 5;
    localparam logic [7:0] MSP_REG_RESET = 8'h00;
    localparam logic [7:0] MSP_BUS_IDLE = 8'hff;

    // host command port map
    localparam logic [2:0] MSP_HC_ADDR_LO = 3'h0;
    localparam logic [2:0] MSP_HC_ADDR_HI = 3'h1;
    localparam logic [2:0] MSP_HC_WDATA = 3'h2;
    localparam logic [2:0] MSP_HC_CMD = 3'h3;
    localparam logic [2:0] MSP_HC_STAT = 3'h4;
    localparam logic [2:0] MSP_HC_RDATA = 3'h5;
    localparam int MSP_HC_GO = 0;
    localparam int MSP_HC_READ = 1;
    localparam int MSP_HC_BUSY = 0;
    localparam int MSP_HC_DONE = 1;

    // host bus phase timing at 8 ns per cycle, least times round up
    localparam int MSP_CLK_NS = 8;
    localparam int MSP_PHASE_NS = 16;
    localparam int MSP_STROBE_NS = 32;
    localparam int MSP_PHASE_CYC =
        (MSP_PHASE_NS + MSP_CLK_NS - 1) / MSP_CLK_NS;
    localparam int MSP_STROBE_CYC =
        (MSP_STROBE_NS + MSP_CLK_NS - 1) / MSP_CLK_NS;

    typedef enum logic [3:0] {
        MSP_D_IDLE = 4'b0001,
        MSP_D_DECODE = 4'b0010,
        MSP_D_XFER = 4'b0100,
        MSP_D_END = 4'b1000
    } msp_dev_st_t;

    typedef enum logic [6:0] {
        MSP_H_IDLE = 7'b0000001,
        MSP_H_ADDR = 7'b0000010,
        MSP_H_SETUP = 7'b0000100,
        MSP_H_STROBE = 7'b0001000,
        MSP_H_HOLD = 7'b0010000,
        MSP_H_NEG = 7'b0100000,
        MSP_H_END = 7'b1000000
    } msp_host_st_t;
endpackage

/* design/msp_bus_if.sv */
// multiplexed address/data bus joining the host and the device
`timescale 1ns/1ns
interface msp_bus_if;
    logic [7:0] addr_hi;
    logic ale_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] host_ad_o;
    logic host_ad_oe_n;
    logic [7:0] dev_ad_o;
    logic dev_ad_oe_n;
    logic [7:0] ad;

    // undriven lines read as pulled high
    assign ad = !dev_ad_oe_n ? dev_ad_o :
                (!host_ad_oe_n ? host_ad_o : msp_pkg::MSP_BUS_IDLE);

    modport dev (
        input addr_hi, ale_n, rd_n, wr_n, ad,
        output dev_ad_o, dev_ad_oe_n
    );
    modport host (
        output addr_hi, ale_n, rd_n, wr_n, host_ad_o, host_ad_oe_n,
        input ad
    );
endinterface

/* design/msp_host.sv */
// host end: runs one multiplexed bus cycle per software command
`timescale 1ns/1ns
module msp_host
    import msp_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic rst, // synchronous reset, active high
    msp_bus_if.host bus, // multiplexed bus to the device
    input wire logic [2:0] cmd_addr, // command register select
    input wire logic [7:0] cmd_wdata, // command write data
    input wire logic cmd_wr, // command write strobe
    input wire logic cmd_rd, // command read strobe
    output logic [7:0] cmd_rdata // read data, one cycle after cmd_rd
);
    typedef struct packed {
        msp_host_st_t st;
        logic [2:0] cnt;
        logic [15:0] tgt;
        logic [7:0] wdat;
        logic is_rd;
        logic [7:0] rbuf;
        logic done;
        logic [7:0] ad_o;
        logic ad_oe_n;
        logic ale_n;
        logic rd_n;
        logic wr_n;
        logic [7:0] rdata;
    } msp_host_state_t;

    localparam logic [2:0] PHASE_LAST = 3'(MSP_PHASE_CYC - 1);
    localparam logic [2:0] STROBE_LAST = 3'(MSP_STROBE_CYC - 1);

    msp_host_state_t s_q;
    msp_host_state_t s_d;
    logic busy;
    logic step;

    assign busy = s_q.st != MSP_H_IDLE;
    assign step = s_q.cnt == 3'h0;

    always_comb
    begin
        s_d = s_q;
        if (!step)
            s_d.cnt = s_q.cnt - 3'h1;
        case (s_q.st)
            MSP_H_IDLE:
            begin
                if (cmd_wr && cmd_addr == MSP_HC_CMD && cmd_wdata[MSP_HC_GO])
                begin
                    s_d.is_rd = cmd_wdata[MSP_HC_READ];
                    s_d.ad_o = s_q.tgt[7:0];
                    s_d.ad_oe_n = 1'b0;
                    s_d.ale_n = 1'b0;
                    s_d.cnt = PHASE_LAST;
                    s_d.st = MSP_H_ADDR;
                end
            end
            MSP_H_ADDR:
            begin
                if (step)
                begin
                    s_d.ad_o = s_q.wdat;
                    s_d.ad_oe_n = s_q.is_rd;
                    s_d.cnt = PHASE_LAST;
                    s_d.st = MSP_H_SETUP;
                end
            end
            MSP_H_SETUP:
            begin
                if (step)
                begin
                    s_d.rd_n = !s_q.is_rd;
                    s_d.wr_n = s_q.is_rd;
                    s_d.cnt = STROBE_LAST;
                    s_d.st = MSP_H_STROBE;
                end
            end
            MSP_H_STROBE:
            begin
                if (step)
                begin
                    if (s_q.is_rd)
                        s_d.rbuf = bus.ad;
                    s_d.ad_oe_n = 1'b1;
                    s_d.cnt = PHASE_LAST;
                    s_d.st = MSP_H_HOLD;
                end
            end
            MSP_H_HOLD:
            begin
                if (step)
                begin
                    s_d.rd_n = 1'b1;
                    s_d.wr_n = 1'b1;
                    s_d.cnt = PHASE_LAST;
                    s_d.st = MSP_H_NEG;
                end
            end
            MSP_H_NEG:
            begin
                if (step)
                begin
                    s_d.ale_n = 1'b1;
                    s_d.cnt = PHASE_LAST;
                    s_d.st = MSP_H_END;
                end
            end
            MSP_H_END:
            begin
                if (step)
                begin
                    s_d.done = 1'b1;
                    s_d.st = MSP_H_IDLE;
                end
            end
            default: s_d.st = MSP_H_IDLE;
        endcase

        // address and data registers are frozen while a cycle runs
        if (cmd_wr && !busy)
        begin
            case (cmd_addr)
                MSP_HC_ADDR_LO: s_d.tgt[7:0] = cmd_wdata;
                MSP_HC_ADDR_HI: s_d.tgt[15:8] = cmd_wdata;
                MSP_HC_WDATA: s_d.wdat = cmd_wdata;
                default: s_d.wdat = s_q.wdat;
            endcase
        end

        s_d.rdata = 8'h00;
        if (cmd_rd)
        begin
            case (cmd_addr)
                MSP_HC_ADDR_LO: s_d.rdata = s_q.tgt[7:0];
                MSP_HC_ADDR_HI: s_d.rdata = s_q.tgt[15:8];
                MSP_HC_WDATA: s_d.rdata = s_q.wdat;
                MSP_HC_STAT:
                begin
                    s_d.rdata[MSP_HC_BUSY] = busy;
                    s_d.rdata[MSP_HC_DONE] = s_q.done;
                end
                MSP_HC_RDATA: s_d.rdata = s_q.rbuf;
                default: s_d.rdata = 8'h00;
            endcase
            // completion landing in the same cycle keeps done set
            if (cmd_addr == MSP_HC_STAT && s_d.done == s_q.done)
                s_d.done = 1'b0;
        end

        if (rst)
        begin
            s_d.st = MSP_H_IDLE;
            s_d.cnt = 3'h0;
            s_d.tgt = 16'h0000;
            s_d.wdat = 8'h00;
            s_d.is_rd = 1'b0;
            s_d.rbuf = 8'h00;
            s_d.done = 1'b0;
            s_d.ad_o = 8'h00;
            s_d.ad_oe_n = 1'b1;
            s_d.ale_n = 1'b1;
            s_d.rd_n = 1'b1;
            s_d.wr_n = 1'b1;
            s_d.rdata = 8'h00;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        s_q <= s_d;
    end

    assign bus.addr_hi = s_q.tgt[15:8];
    assign bus.ale_n = s_q.ale_n;
    assign bus.rd_n = s_q.rd_n;
    assign bus.wr_n = s_q.wr_n;
    assign bus.host_ad_o = s_q.ad_o;
    assign bus.host_ad_oe_n = s_q.ad_oe_n;
    assign cmd_rdata = s_q.rdata;
endmodule

/* tb/msp_asserts.sv */
// bus protocol assertions for the joined host and device ends
`timescale 1ns/1ns
module msp_asserts
    import msp_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic [7:0] addr_hi, // high address byte
    input wire logic ale_n, // address latch, active low
    input wire logic rd_n, // read strobe, active low
    input wire logic wr_n, // write strobe, active low
    input wire logic [7:0] host_ad_o, // host drive value
    input wire logic host_ad_oe_n, // low while host drives
    input wire logic [7:0] dev_ad_o, // device drive value
    input wire logic dev_ad_oe_n, // low while device drives
    input wire logic [7:0] ad // resolved shared lines
);
    logic ale_n_q;
    logic [7:0] alo_q;
    logic adr_ok;

    // own copy of the low address so the decode is judged independently
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ale_n_q <= 1'b1;
            alo_q <= 8'h00;
        end
        else
        begin
            ale_n_q <= ale_n;
            if (ale_n_q && !ale_n)
                alo_q <= ad;
        end
    end
    assign adr_ok = addr_hi == MSP_STATUS_ADDR[15:8]
                    && alo_q[7:4] == MSP_STATUS_ADDR[7:4];

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    ale_span_a: assert property ($fell(ale_n) |-> !ale_n [*8])
        else $error("address latch dropped early");
    ale_end_a: assert property ($rose(ale_n) |-> rd_n && wr_n
        && dev_ad_oe_n) else $error("latch negated inside a transfer");
    wr_data_a: assert property ($fell(wr_n) |-> !host_ad_oe_n
        && $stable(host_ad_o) && ad == host_ad_o)
        else $error("write strobe without settled data");
    strobe_excl_a: assert property (rd_n || wr_n)
        else $error("both strobes low");
    rd_float_a: assert property (!rd_n |-> host_ad_oe_n)
        else $error("host drives during read strobe");
    rd_drive_a: assert property ($fell(rd_n) && adr_ok
        |=> !dev_ad_oe_n && ad == dev_ad_o)
        else $error("device did not drive read data");
    rd_hold_a: assert property ($rose(rd_n) && adr_ok
        |-> !$past(dev_ad_oe_n)) else $error("read data gone early");
    wr_release_a: assert property ($rose(wr_n) |-> host_ad_oe_n)
        else $error("host still drives at write strobe end");
    end_float_a: assert property (rd_n && wr_n && $past(rd_n)
        && $past(wr_n) |-> dev_ad_oe_n)
        else $error("device drives after strobes ended");
    no_match_a: assert property (!ale_n && !rd_n && !adr_ok
        |-> dev_ad_oe_n) else $error("unaddressed device drives");
    reset_float_a: assert property ($fell(rst) |-> dev_ad_oe_n
        && host_ad_oe_n && ale_n && rd_n && wr_n)
        else $error("bus not idle after reset");
endmodule

/* tb/tb_top.sv */
// self-checking bench: host and device ends joined by the bus
`timescale 1ns/1ns
module tb_top
    import msp_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] cmd_addr = 3'h0;
    logic [7:0] cmd_wdata = 8'h00;
    logic cmd_wr = 1'b0;
    logic cmd_rd = 1'b0;
    logic [7:0] cmd_rdata;
    logic spi_done = 1'b0;
    logic spi_bus_active = 1'b0;
    logic ss_in_n = 1'b1;
    logic tx_taken = 1'b0;
    logic rx_valid = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic [7:0] ctrl_out, target_sel, tx_byte;
    logic tx_empty, rx_full, int_n, spi_abort;
    int err_count = 0;
    int total_checks = 0;

    always #4 sys_clk = ~sys_clk;

    msp_bus_if u_msp_bus_if();
    msp_host u_msp_host(.sys_clk, .rst, .bus(u_msp_bus_if), .cmd_addr,
        .cmd_wdata, .cmd_wr, .cmd_rd, .cmd_rdata);
    msp_dev u_msp_dev(.sys_clk, .rst, .bus(u_msp_bus_if), .spi_done,
        .spi_bus_active, .ss_in_n, .tx_taken, .rx_valid, .rx_byte,
        .ctrl_out, .target_sel, .tx_byte, .tx_empty, .rx_full, .int_n,
        .spi_abort);
    msp_asserts u_msp_asserts(.sys_clk, .rst,
        .addr_hi(u_msp_bus_if.addr_hi), .ale_n(u_msp_bus_if.ale_n),
        .rd_n(u_msp_bus_if.rd_n), .wr_n(u_msp_bus_if.wr_n),
        .host_ad_o(u_msp_bus_if.host_ad_o),
        .host_ad_oe_n(u_msp_bus_if.host_ad_oe_n),
        .dev_ad_o(u_msp_bus_if.dev_ad_o),
        .dev_ad_oe_n(u_msp_bus_if.dev_ad_oe_n), .ad(u_msp_bus_if.ad));

    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic cmd_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        @(posedge sys_clk);
        cmd_wr <= 1'b0;
    endtask

    task automatic cmd_read(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        cmd_addr <= a;
        cmd_rd <= 1'b1;
        @(posedge sys_clk);
        cmd_rd <= 1'b0;
        #1 d = cmd_rdata;
    endtask

    // one full bus cycle; done is sticky until the status poll sees it
    task automatic access(input logic [15:0] a, input logic wr,
        input logic [7:0] wd, output logic [7:0] rd);
        logic [7:0] st;
        int n;
        cmd_write(MSP_HC_ADDR_LO, a[7:0]);
        cmd_write(MSP_HC_ADDR_HI, a[15:8]);
        cmd_write(MSP_HC_WDATA, wd);
        cmd_write(MSP_HC_CMD, wr ? 8'h01 : 8'h03);
        n = 0;
        st = 8'h00;
        while (st[MSP_HC_DONE] !== 1'b1)
        begin
            if (n == 50)
            begin
                err_count++;
                give_verdict();
            end
            n++;
            cmd_read(MSP_HC_STAT, st);
        end
        cmd_read(MSP_HC_RDATA, rd);
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] v;
        access(a, 1'b1, d, v);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] v;
        access(a, 1'b0, 8'h00, v);
        check(v, exp);
    endtask

    task automatic sc_reset;
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        check({5'h0, tx_empty, rx_full, int_n}, 8'h05);
        rd_chk(MSP_STATUS_ADDR, 8'h18);
        rd_chk(MSP_CONTROL_ADDR, 8'h00);
    endtask

    task automatic sc_regs;
        wr_reg(MSP_TARGET_ADDR, 8'ha5);
        rd_chk(MSP_TARGET_ADDR, 8'ha5);
        check(target_sel, 8'ha5);
        wr_reg(MSP_BASE + 16'h0188, 8'h11);
        check(target_sel, 8'ha5);
        rd_chk(MSP_BASE + 16'h0188, MSP_BUS_IDLE);
        wr_reg(MSP_BASE + 16'h0081, 8'h22);
        rd_chk(MSP_BASE + 16'h0081, 8'h00);
        wr_reg(MSP_CONTROL_ADDR, 8'h8c);
        rd_chk(MSP_CONTROL_ADDR, 8'h8c);
        check(ctrl_out, 8'h8c);
        wr_reg(MSP_CONTROL_ADDR, 8'h00);
        wr_reg(MSP_TX_ADDR, 8'h3c);
        check({tx_byte[7:1], tx_empty}, 8'h3c);
    endtask

    task automatic sc_live;
        @(posedge sys_clk);
        spi_done <= 1'b1;
        spi_bus_active <= 1'b1;
        rd_chk(MSP_STATUS_ADDR, 8'hb0);
        wr_reg(MSP_STATUS_ADDR, 8'h00);
        rd_chk(MSP_STATUS_ADDR, 8'hb0);
        @(posedge sys_clk);
        spi_done <= 1'b0;
        spi_bus_active <= 1'b0;
        rd_chk(MSP_STATUS_ADDR, 8'h10);
    endtask

    task automatic sc_rx;
        @(posedge sys_clk);
        rx_valid <= 1'b1;
        rx_byte <= 8'h96;
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rd_chk(MSP_STATUS_ADDR, 8'h04);
        check({7'h0, int_n}, 8'h01);
        wr_reg(MSP_CONTROL_ADDR, 8'h40);
        check({6'h0, rx_full, int_n}, 8'h02);
        wr_reg(MSP_CONTROL_ADDR, 8'h00);
        check({7'h0, int_n}, 8'h01);
        rd_chk(MSP_STATUS_ADDR, 8'h04);
        wr_reg(MSP_CONTROL_ADDR, 8'h40);
        rd_chk(MSP_RX_ADDR, 8'h96);
        check({6'h0, rx_full, int_n}, 8'h01);
    endtask

    task automatic sc_tx;
        rd_chk(MSP_STATUS_ADDR, 8'h10);
        wr_reg(MSP_CONTROL_ADDR, 8'h60);
        @(posedge sys_clk);
        tx_taken <= 1'b1;
        @(posedge sys_clk);
        tx_taken <= 1'b0;
        rd_chk(MSP_STATUS_ADDR, 8'h08);
        check({6'h0, tx_empty, int_n}, 8'h02);
        wr_reg(MSP_TX_ADDR, 8'h77);
        check({6'h0, tx_empty, int_n}, 8'h01);
    endtask

    // a clear while the select input is still held must not stick
    task automatic sc_conflict;
        wr_reg(MSP_CONTROL_ADDR, 8'h40);
        @(posedge sys_clk);
        ss_in_n <= 1'b0;
        rd_chk(MSP_STATUS_ADDR, 8'h40);
        check({6'h0, spi_abort, int_n}, 8'h02);
        wr_reg(MSP_STATUS_ADDR, 8'h00);
        check({7'h0, spi_abort}, 8'h01);
        @(posedge sys_clk);
        ss_in_n <= 1'b1;
        wr_reg(MSP_STATUS_ADDR, 8'h00);
        rd_chk(MSP_STATUS_ADDR, 8'h10);
        check({6'h0, spi_abort, int_n}, 8'h01);
    endtask

    initial
    begin
        sc_reset();
        sc_regs();
        sc_live();
        sc_rx();
        sc_tx();
        sc_conflict();
        sc_reset();
        give_verdict();
    end
endmodule
